// File: irq_pkg.sv
// package: constants and carrier types for vector placement and external irq logic
// assumes: single 250 MHz clock domain, program word addressing
package irq_pkg;

  localparam int unsigned  PC_WIDTH       = 16;
  localparam int unsigned  PIN_COUNT      = 28;
  localparam int unsigned  GROUP_COUNT    = 4;
  localparam int unsigned  SRC_COUNT      = 6;

  localparam logic [15:0]  RESET_ADDR     = 16'h0000;
  localparam logic [15:0]  TABLE_START    = 16'h0001;
  localparam logic [15:0]  BOOT_ADDR_DFLT = 16'h0c00;
  localparam logic [15:0]  LAST_VECTOR    = 16'h0016;

  // group bounds on the pin-change inputs
  localparam int unsigned  G0_LO = 0;
  localparam int unsigned  G1_LO = 8;
  localparam int unsigned  G2_LO = 16;
  localparam int unsigned  G3_LO = 24;
  localparam int unsigned  G3_HI = 27;

  // vector index of pin A, first in priority order; the other sources follow it
  localparam logic [4:0]   VEC_PIN_A = 5'h01;

  // sense control encodings
  typedef enum logic [1:0]
  {
    SENSE_LOW     = 2'b00,
    SENSE_ANY     = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING  = 2'b11
  } sense_t;

  typedef struct packed
  {
    logic [27:0] pin_change_mask;
    logic [3:0]  pin_change_group_enable;
    sense_t      sense_b;
    sense_t      sense_a;
    logic [1:0]  pin_irq_enable;
  } irq_cfg_t;

  typedef struct packed
  {
    logic        valid;
    logic [4:0]  vector_index;
    logic [15:0] vector_addr;
  } irq_req_t;

endpackage : irq_pkg

// File: sync2.sv
// module: two flip-flop synchroniser for a bus of levels
// assumes: inputs are asynchronous to clk; reset is the synchronised copy
module sync2
  import irq_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : sync2

// File: pin_sense.sv
// module: sense logic for one dedicated interrupt pin
// assumes: pin_level already synchronised; clear comes from the core on clk
module pin_sense
  import irq_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   pin_level,
  input  wire sense_t sense,
  input  wire logic   clear,
  output logic        request
);

  logic prev_ff;
  logic flag_ff;
  logic nxt_prev;
  logic nxt_flag;
  logic edge_hit;

  always_comb
  begin
    nxt_prev = pin_level;
    unique case (sense)
      SENSE_ANY:     edge_hit = pin_level ^ prev_ff;
      SENSE_FALLING: edge_hit = prev_ff & ~pin_level;
      SENSE_RISING:  edge_hit = ~prev_ff & pin_level;
      SENSE_LOW:     edge_hit = 1'b0;
    endcase
    // set wins over clear so an edge on the clear cycle is kept
    nxt_flag = edge_hit | (flag_ff & ~clear); // RL18
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_ff <= 1'b1;
      flag_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev; // RL11
      flag_ff <= nxt_flag;
    end
  end

  // level mode is not latched: request follows the pin while it stays low
  assign request = (sense == SENSE_LOW) ? ~pin_level : flag_ff; // RL10 RL16

endmodule : pin_sense

// File: irq_vector_unit.sv
// Functional notes
// RL1 - relocate select adds boot start address to every vector
// RL2 - programmed boot fuse starts execution at boot loader address
// RL3 - reset 0x000 or boot; table at 0x001 or boot plus one
// RL4 - pin activity raises interrupts even when the pin is an output
// RL5 - each pin-change group fires on any enabled input toggle
// RL6 - per-input mask bits choose which pins feed their group
// RL7 - pin changes seen asynchronously to allow wake from deep sleep; here they pass sync2 and are found on clk
// RL8 - pin-change needs I/O clock; source holds state until awake
// RL9 - pin returning to start during wake gives no interrupt
// RL10 - dedicated pins: falling, rising, low level; level asserts while low
// RL11 - edge detection needs the running I/O clock
// RL12 - low-level detection is asynchronous and wakes from sleep; here the raw level reaches wake_request through a flop on clk
// RL13 - level wake must be held through start-up or no interrupt
// RL14 - level gone before wake: no vector, resume after sleep
// RL15 - vectors consecutive: reset 0, pin A 1, up to 0x16
// RL16 - two-bit sense: low, any change, falling, rising
// RL17 - pin-change needs both pin mask bit and group enable
// RL18 - dedicated pins synchronised, requests latched until cleared
//
// file: top of vector placement and external interrupt detection
// assumes: core takes one request at a time and pulses the ack on entry
module irq_vector_unit
  import irq_pkg::*;
#(
  parameter logic [15:0] BOOT_ADDR = BOOT_ADDR_DFLT
)
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 boot_reset_select_fuse,
  input  wire logic                 vector_relocate_select,
  input  wire irq_cfg_t             cfg,
  input  wire logic                 ext_irq_pin_a,
  input  wire logic                 ext_irq_pin_b,
  input  wire logic [PIN_COUNT-1:0] pin_change_input,
  input  wire logic [1:0]           pin_irq_clear,
  input  wire logic [3:0]           group_clear,
  input  wire logic                 irq_ack,
  output logic      [15:0]          reset_vector,
  output irq_req_t                  irq_req,
  output logic      [1:0]           pin_irq_flag,
  output logic      [3:0]           group_flag,
  output logic                      wake_request
);

  // ********************************
  // reset release
  // ********************************
  logic rst_meta_ff;
  logic rst_n_ff;
  logic nxt_rst_meta;
  logic nxt_rst_n;

  // release is synchronous so no flop leaves reset a cycle before another
  always_comb
  begin
    nxt_rst_meta = 1'b1;
    nxt_rst_n    = rst_meta_ff;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= nxt_rst_meta;
      rst_n_ff    <= nxt_rst_n;
    end
  end

  // ********************************
  // pin synchronisers
  // ********************************
  // pins are read whatever their port direction, so software can self-trigger
  // dedicated pins pass inverted: the synchroniser resets to 0, which must
  // read as the idle high level or reset release looks like a falling edge
  logic [1:0]           ded_sync_inv;
  logic [1:0]           ded_sync;
  logic [PIN_COUNT-1:0] pc_sync;

  sync2 #(.WIDTH(2)) u_ded_sync
  (
    .clk      (clk),
    .rst_n    (rst_n_ff),
    .async_in (~{ext_irq_pin_b, ext_irq_pin_a}), // RL4
    .sync_out (ded_sync_inv)
  );

  assign ded_sync = ~ded_sync_inv;

  sync2 #(.WIDTH(PIN_COUNT)) u_pc_sync
  (
    .clk      (clk),
    .rst_n    (rst_n_ff),
    .async_in (pin_change_input), // RL4
    .sync_out (pc_sync)
  );

  // ********************************
  // acknowledge decode
  // ********************************
  // the ack names the request shown in the same cycle, so it clears that source only
  function automatic logic ack_match(input logic ack, input irq_req_t req,
                                     input logic [4:0] src);
    ack_match = ack && req.valid && (req.vector_index == VEC_PIN_A + src);
  endfunction : ack_match

  logic [SRC_COUNT-1:0] ack_src;

  always_comb
  begin
    ack_src = '0;
    for (int s = 0; s < SRC_COUNT; s++)
    begin
      ack_src[s] = ack_match(irq_ack, irq_req, 5'(s));
    end
  end

  // ********************************
  // dedicated pin sensing
  // ********************************
  logic [1:0] ded_req;

  pin_sense u_sense_a
  (
    .clk       (clk),
    .rst_n     (rst_n_ff),
    .pin_level (ded_sync[0]), // RL18
    .sense     (cfg.sense_a),
    .clear     (pin_irq_clear[0] | ack_src[0]),
    .request   (ded_req[0])
  );

  pin_sense u_sense_b
  (
    .clk       (clk),
    .rst_n     (rst_n_ff),
    .pin_level (ded_sync[1]), // RL18
    .sense     (cfg.sense_b),
    .clear     (pin_irq_clear[1] | ack_src[1]),
    .request   (ded_req[1])
  );

  // ********************************
  // pin-change groups
  // ********************************
  function automatic logic [3:0] group_or(input logic [PIN_COUNT-1:0] hits);
    group_or[0] = |hits[G1_LO-1:G0_LO];
    group_or[1] = |hits[G2_LO-1:G1_LO];
    group_or[2] = |hits[G3_LO-1:G2_LO];
    group_or[3] = |hits[G3_HI:G3_LO];
  endfunction : group_or

  function automatic logic [PIN_COUNT-1:0] group_spread(input logic [3:0] en);
    group_spread = {{(G3_HI-G3_LO+1){en[3]}}, {(G3_LO-G2_LO){en[2]}},
                    {(G2_LO-G1_LO){en[1]}}, {(G1_LO-G0_LO){en[0]}}};
  endfunction : group_spread

  logic [PIN_COUNT-1:0] pc_prev_ff;
  logic [PIN_COUNT-1:0] nxt_pc_prev;
  logic [3:0]           group_ff;
  logic [3:0]           nxt_group;
  logic [PIN_COUNT-1:0] pc_enabled;
  logic [3:0]           group_hit;

  always_comb
  begin
    // only a level that survived synchronisation counts; a pin that toggles
    // back before the clock runs again leaves no change behind
    nxt_pc_prev = pc_sync; // RL9 RL8
    pc_enabled  = cfg.pin_change_mask & group_spread(cfg.pin_change_group_enable); // RL6 RL17
    group_hit   = group_or((pc_sync ^ pc_prev_ff) & pc_enabled); // RL5
    // set wins over clear and ack so a change in the clearing cycle is kept
    nxt_group   = group_hit | (group_ff & ~group_clear & ~ack_src[SRC_COUNT-1:2]);
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pc_prev_ff <= '0;
      group_ff   <= '0;
    end
    else
    begin
      pc_prev_ff <= nxt_pc_prev;
      group_ff   <= nxt_group;
    end
  end

  // ********************************
  // priority and vector placement
  // ********************************
  logic [SRC_COUNT-1:0] pending;
  irq_req_t             nxt_req;
  irq_req_t             req_ff;
  logic [15:0]          table_base;

  always_comb
  begin
    pending = {group_ff, ded_req & cfg.pin_irq_enable};
    // relocation shifts the whole table by the boot start
    table_base = vector_relocate_select ? BOOT_ADDR + TABLE_START : TABLE_START; // RL1 RL3
    nxt_req = '0;
    for (int s = SRC_COUNT - 1; s >= 0; s--)
    begin
      if (pending[s])
      begin
        nxt_req.valid        = 1'b1;
        nxt_req.vector_index = VEC_PIN_A + 5'(s); // RL15
        nxt_req.vector_addr  = table_base + 16'(s); // RL1 RL15
      end
    end
    // a low level that is gone leaves nothing pending, so no vector is taken
    if (irq_ack)
    begin
      nxt_req.valid = 1'b0; // RL14 RL13
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      req_ff <= '0;
    end
    else
    begin
      req_ff <= nxt_req;
    end
  end

  // ********************************
  // reset address
  // ********************************
  logic [15:0] nxt_reset_vec;
  logic [15:0] reset_vec_ff;

  // the fuse is static in use, so it is registered every cycle and not synchronised
  always_comb
  begin
    nxt_reset_vec = boot_reset_select_fuse ? BOOT_ADDR : RESET_ADDR; // RL2 RL3
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      reset_vec_ff <= RESET_ADDR;
    end
    else
    begin
      reset_vec_ff <= nxt_reset_vec;
    end
  end

  // ********************************
  // wake request
  // ********************************
  logic       nxt_wake;
  logic       wake_ff;
  logic [1:0] level_low;

  always_comb
  begin
    // raw pin levels on purpose: the clock may be stopped, so no synchroniser
    level_low = ~{ext_irq_pin_b, ext_irq_pin_a} & cfg.pin_irq_enable
                & {cfg.sense_b == SENSE_LOW, cfg.sense_a == SENSE_LOW}; // RL12
    nxt_wake  = (|level_low) | (|pending); // RL7
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      wake_ff <= 1'b0;
    end
    else
    begin
      wake_ff <= nxt_wake;
    end
  end

  // ********************************
  // outputs
  // ********************************
  logic [1:0] ded_flag_ff;
  logic [1:0] nxt_ded_flag;

  always_comb
  begin
    nxt_ded_flag = ded_req;
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      ded_flag_ff <= '0;
    end
    else
    begin
      ded_flag_ff <= nxt_ded_flag;
    end
  end

  assign irq_req      = req_ff;
  assign reset_vector = reset_vec_ff;
  assign pin_irq_flag = ded_flag_ff;
  assign group_flag   = group_ff;
  assign wake_request = wake_ff;

endmodule : irq_vector_unit

// File: irq_vector_unit_sva.sv
// checker: port-level properties of the vector and external irq unit
// assumes: single clock, bound to every irq_vector_unit instance
module irq_vector_unit_sva
  import irq_pkg::*;
#(
  parameter logic [15:0] BOOT_ADDR = BOOT_ADDR_DFLT
)
(
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 boot_reset_select_fuse,
  input wire logic                 vector_relocate_select,
  input wire irq_cfg_t             cfg,
  input wire logic                 ext_irq_pin_a,
  input wire logic                 ext_irq_pin_b,
  input wire logic [PIN_COUNT-1:0] pin_change_input,
  input wire logic [1:0]           pin_irq_clear,
  input wire logic [3:0]           group_clear,
  input wire logic                 irq_ack,
  input wire logic [15:0]          reset_vector,
  input wire irq_req_t             irq_req,
  input wire logic [1:0]           pin_irq_flag,
  input wire logic [3:0]           group_flag,
  input wire logic                 wake_request
);
  // ****************************************
  // settle counter: internal reset lags arst_n
  // ****************************************
  logic [2:0] rel_ff;
  logic [2:0] nxt_rel;
  logic       ok;
  always_comb nxt_rel = (rel_ff == 3'h7) ? rel_ff : rel_ff + 3'h1;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) rel_ff <= 3'h0;
    else rel_ff <= nxt_rel;
  assign ok = (rel_ff == 3'h7);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_reset_addr_sel: assert property (ok |=> reset_vector ==
    ($past(boot_reset_select_fuse) ? BOOT_ADDR : RESET_ADDR)) else $error("reset vector wrong");
  a_vec_place_base: assert property (ok && irq_req.valid && $stable(vector_relocate_select)
    |-> irq_req.vector_addr == (vector_relocate_select ? BOOT_ADDR : 16'h0000)
    + {11'h000, irq_req.vector_index}) else $error("vector address wrong");
  a_vec_index_range: assert property (irq_req.valid |->
    irq_req.vector_index inside {[5'h01:5'h06]}) else $error("vector index out of range");
  a_group_needs_enable: assert property (ok |-> ((group_flag & ~$past(group_flag))
    & ~$past(cfg.pin_change_group_enable)) == 4'h0) else $error("disabled group set");
  a_group_flag_sticky: assert property (ok && !$past(irq_ack) |->
    ($past(group_flag) & ~$past(group_clear) & ~group_flag) == 4'h0) else $error("flag lost");
  a_ack_drops_valid: assert property (ok && irq_req.valid && irq_ack && $onehot(group_flag)
    && irq_req.vector_index >= 5'h03 && pin_irq_flag == 2'b00 |=> !irq_req.valid)
    else $error("valid held after ack");
  a_wake_on_pending: assert property (ok && |group_flag |-> ##[0:2] wake_request)
    else $error("no wake for pending group");
  a_level_low_req: assert property ((ok && cfg.pin_irq_enable[0]
    && cfg.sense_a == SENSE_LOW && !ext_irq_pin_a && !irq_ack)[*6]
    |-> pin_irq_flag[0] && irq_req.valid)
    else $error("low level not requesting");
endmodule : irq_vector_unit_sva
bind irq_vector_unit irq_vector_unit_sva #(.BOOT_ADDR(BOOT_ADDR)) u_sva (.clk(clk),
  .arst_n(arst_n), .boot_reset_select_fuse(boot_reset_select_fuse),
  .vector_relocate_select(vector_relocate_select), .cfg(cfg), .ext_irq_pin_a(ext_irq_pin_a),
  .ext_irq_pin_b(ext_irq_pin_b), .pin_change_input(pin_change_input),
  .pin_irq_clear(pin_irq_clear), .group_clear(group_clear), .irq_ack(irq_ack),
  .reset_vector(reset_vector), .irq_req(irq_req), .pin_irq_flag(pin_irq_flag),
  .group_flag(group_flag), .wake_request(wake_request));

// File: core_model.sv
// model: processor core taking one request at a time with a pulsed ack
// assumes: requests stay valid until acked; ack launched 1 ns after an edge
module core_model
  import irq_pkg::*;
(
  input  wire logic     clk,
  input  wire irq_req_t irq_req,
  input  wire logic     ack_en,
  input  wire logic [1:0] ack_delay,
  output logic          irq_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  // extra idle edge after each ack so a stale valid is never taken twice
  initial
  begin
    irq_ack = 1'b0;
    forever
    begin
      @(posedge clk);
      if (irq_req.valid === 1'b1 && ack_en)
      begin
        repeat (ack_delay) @(posedge clk);
        #1 irq_ack = 1'b1;
        @(posedge clk);
        #1 irq_ack = 1'b0;
        @(posedge clk);
      end
    end
  end
endmodule : core_model

// File: vector_placement_and_external_irq_bench.sv
// bench: drives pins and placement controls, checks taken vectors in order
// assumes: core_model acks; clears tied low, edge and group flags leave through acks, the low-level flag follows the pin
module vector_placement_and_external_irq_bench;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] BOOT = 16'h0c00;
  logic clk = 1'b0, arst_n = 1'b0, fuse = 1'b0, reloc = 1'b0, pa = 1'b1, pb = 1'b1;
  logic ack, wake, core_en = 1'b1;
  logic [1:0]  core_delay = 2'h0, pflag;
  logic [3:0]  gflag;
  logic [15:0] rv;
  logic [27:0] pins = 28'h0;
  irq_cfg_t    cfg = '0;
  irq_req_t    req;
  logic [20:0] exp_q[$];
  int          err_count = 0, checks_done = 0;
  always #2 clk = ~clk;
  irq_vector_unit #(.BOOT_ADDR(BOOT)) u_dut (.clk(clk), .arst_n(arst_n),
    .boot_reset_select_fuse(fuse), .vector_relocate_select(reloc), .cfg(cfg),
    .ext_irq_pin_a(pa), .ext_irq_pin_b(pb), .pin_change_input(pins), .pin_irq_clear(2'b00),
    .group_clear(4'h0), .irq_ack(ack), .reset_vector(rv), .irq_req(req),
    .pin_irq_flag(pflag), .group_flag(gflag), .wake_request(wake));
  core_model u_core (.clk(clk), .irq_req(req), .ack_en(core_en), .ack_delay(core_delay),
    .irq_ack(ack));
  // ****************************************
  // helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(string what, logic [20:0] exp, logic [20:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200)
    begin
      step(1);
      n++;
    end
    if (exp_q.size() != 0)
    begin
      err_count++;
      wrap_up();
    end
    step(8);
  endtask : drain
  task automatic pulse(int p);
    if (p == 0) pa = 1'b0; else pb = 1'b0;
    step(8);
    if (p == 0) pa = 1'b1; else pb = 1'b1;
  endtask : pulse
  function automatic logic [20:0] vec(logic [4:0] idx);
    return {idx, (reloc ? BOOT : 16'h0000) + {11'h000, idx}};
  endfunction : vec
  // taken requests are checked oldest note first
  always @(posedge clk)
    if (req.valid === 1'b1 && ack === 1'b1)
      cmp("vector", (exp_q.size() != 0) ? exp_q.pop_front() : 21'h0, {req.vector_index,
        req.vector_addr});
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    int k, g, s, rnd;
    rnd = $urandom(75967);
    step(2);
    arst_n = 1'b1;
    step(6);
    for (k = 0; k < 4; k++)
    begin
      {fuse, reloc} = k[1:0];
      step(3);
      cmp("reset_vector", {5'h00, fuse ? BOOT : RESET_ADDR}, {5'h00, rv});
    end
    cfg.pin_change_group_enable = 4'hf;
    for (g = 0; g < 4; g++)
    begin
      k = (g == 3) ? 24 + $urandom_range(3) : 8 * g + $urandom_range(7);
      reloc = 1'($urandom_range(1));
      core_delay = 2'($urandom_range(3));
      cfg.pin_change_mask = 28'h0;
      cfg.pin_change_mask[k] = 1'b1;
      step(2);
      exp_q.push_back(vec(5'(3 + g)));
      pins[k] = ~pins[k];
      drain();
    end
    cfg.pin_change_mask = ~28'h1;
    cfg.pin_change_group_enable = 4'h7;
    step(2);
    pins[0] = ~pins[0];
    pins[25] = ~pins[25];
    #1 pins[9] = ~pins[9];
    #1 pins[9] = ~pins[9];
    step(10);
    cmp("group_flag", 21'h0, {17'h0, gflag});
    cfg.pin_change_group_enable = 4'hf;
    core_delay = 2'h3;
    step(2);
    exp_q.push_back(vec(5'h03));
    exp_q.push_back(vec(5'h06));
    pins[1] = ~pins[1];
    pins[26] = ~pins[26];
    drain();
    core_delay = 2'h0;
    for (k = 0; k < 2; k++)
      for (s = 1; s < 4; s++)
      begin
        cfg.pin_irq_enable = 2'b01 << k;
        if (k == 0) cfg.sense_a = sense_t'(s); else cfg.sense_b = sense_t'(s);
        step(4);
        repeat ((s == 1) ? 2 : 1) exp_q.push_back(vec(5'(k + 1)));
        pulse(k);
        drain();
      end
    core_en = 1'b0;
    cfg.pin_irq_enable = 2'b01;
    cfg.sense_a = SENSE_LOW;
    step(2);
    pa = 1'b0;
    step(8);
    cmp("level_req", vec(5'h01), {req.vector_index, req.vector_addr});
    cmp("level_valid", 21'h1, {20'h0, req.valid});
    cmp("level_flag", 21'h1, {20'h0, pflag[0]});
    cmp("level_wake", 21'h1, {20'h0, wake});
    pa = 1'b1;
    step(8);
    cmp("level_gone", 21'h0, {20'h0, req.valid});
    cmp("flag_gone", 21'h0, {19'h0, pflag});
    cmp("wake_gone", 21'h0, {20'h0, wake});
    wrap_up();
  end
endmodule : vector_placement_and_external_irq_bench
